//--- hw/shift_move_indirect_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "shift_move_indirect_regs.svh"

module shift_move_indirect_exec
    import shift_move_indirect_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic opValid,
    input wire op_t opCode,
    input wire logic [`FILE_ADDR_W-1:0] fileAddr,
    input wire logic [`DATA_W-1:0] fileData,
    input wire logic destSel,
    input wire logic ptrIndex,
    input wire logic [1:0] updateMode,
    input wire logic [`OFFSET_W-1:0] offset,
    input wire logic ptrLoadEn,
    input wire logic ptrLoadSel,
    input wire logic [`PTR_W-1:0] ptrLoadData,
    input wire logic memRdValid,
    input wire logic [`DATA_W-1:0] memRdData,
    output logic opReady,
    output logic [`DATA_W-1:0] acc,
    output logic carryFlag,
    output logic zeroFlag,
    output logic fileWrEn,
    output logic [`FILE_ADDR_W-1:0] fileWrAddr,
    output logic [`DATA_W-1:0] fileWrData,
    output logic memRdReq,
    output logic [`PTR_W-1:0] memAddr,
    output logic [`PTR_W-1:0] ptr0,
    output logic [`PTR_W-1:0] ptr1
);
    state_t state, next_state;
    logic [`DATA_W-1:0] next_acc;
    logic next_carryFlag;
    logic next_zeroFlag;
    logic next_fileWrEn;
    logic [`FILE_ADDR_W-1:0] next_fileWrAddr;
    logic [`DATA_W-1:0] next_fileWrData;
    logic next_memRdReq;
    logic [`PTR_W-1:0] next_memAddr;
    logic [`DATA_W-1:0] result;
    // address path and per-pointer controls
    logic [`PTR_W-1:0] basePtr;
    logic [`PTR_W-1:0] stepPtr;
    logic [`PTR_W-1:0] offsetAddr;
    logic stepDown;
    logic postMode;
    logic accept;
    logic isIndirect;
    logic isOffset;
    logic step0;
    logic step1;
    logic load0;
    logic load1;

    // new work is taken only while no indirect read is outstanding
    assign opReady = (state == ST_IDLE);
    assign accept = opValid && opReady;
    assign isOffset = (opCode == OP_INDIRECT_LOAD_OFFSET);
    assign isIndirect = (opCode == OP_INDIRECT_LOAD_ACC) || isOffset;

    // pointer choice and address arithmetic
    assign basePtr = ptrIndex ? ptr1 : ptr0;
    assign stepDown = updateMode[`MODE_DOWN_BIT];
    assign postMode = updateMode[`MODE_POST_BIT];
    assign stepPtr = stepDown ? basePtr - `PTR_W'(1)
                              : basePtr + `PTR_W'(1);
    // sign extension keeps the sum modulo 2^16 like the pointer itself
    assign offsetAddr = basePtr
        + {{(`PTR_W-`OFFSET_W){offset[`OFFSET_W-1]}}, offset};

    // pointer steps only for the mode forms; a software load wins
    assign step0 = accept && isIndirect && !isOffset && !ptrIndex;
    assign step1 = accept && isIndirect && !isOffset && ptrIndex;
    assign load0 = ptrLoadEn && !ptrLoadSel;
    assign load1 = ptrLoadEn && ptrLoadSel;

    pointer_unit #(
        .WIDTH(`PTR_W)
    ) u_ptr0 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .loadEn(load0),
        .loadData(ptrLoadData),
        .stepEn(step0),
        .stepDown(stepDown),
        .value(ptr0)
    );

    pointer_unit #(
        .WIDTH(`PTR_W)
    ) u_ptr1 (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .loadEn(load1),
        .loadData(ptrLoadData),
        .stepEn(step1),
        .stepDown(stepDown),
        .value(ptr1)
    );

    // shift and move results from the operand byte
    // the decoder fetches the operand, so no file read port is needed here
    always_comb begin
        case (opCode)
            OP_SHIFT_LEFT_LOGICAL: begin
                result = {fileData[`DATA_W-2:0], 1'b0};
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
                result = {1'b0, fileData[`DATA_W-1:1]};
            end
            OP_MOVE_FILE: begin
                result = fileData;
            end
            default: begin
                result = fileData;
            end
        endcase
    end

    // sequencer and architectural state
    always_comb begin
        next_state = state;
        next_acc = acc;
        next_carryFlag = carryFlag;
        next_zeroFlag = zeroFlag;
        next_fileWrEn = 1'b0;
        next_fileWrAddr = fileWrAddr;
        next_fileWrData = fileWrData;
        next_memRdReq = 1'b0;
        next_memAddr = memAddr;
        case (state)
            ST_IDLE: begin
                if (accept && isIndirect) begin
                    // indirect loads always land in the accumulator and
                    // leave carry alone; only the shifts move it
                    // pre modes address the stepped pointer, post the old one
                    if (isOffset) begin
                        next_memAddr = offsetAddr;
                    end else if (postMode) begin
                        next_memAddr = basePtr;
                    end else begin
                        next_memAddr = stepPtr;
                    end
                    next_memRdReq = 1'b1;
                    next_state = ST_WAIT;
                end else if (accept) begin
                    // single cycle: result lands at the next edge, no stall
                    if (opCode == OP_SHIFT_LEFT_LOGICAL) begin
                        next_carryFlag = fileData[`DATA_W-1];
                    end
                    if (opCode == OP_SHIFT_RIGHT_LOGICAL) begin
                        next_carryFlag = fileData[0];
                    end
                    next_zeroFlag = (result == `DATA_W'(0));
                    if (destSel == `DEST_FILE) begin
                        next_fileWrEn = 1'b1;
                        next_fileWrAddr = fileAddr;
                        next_fileWrData = result;
                    end else begin
                        next_acc = result;
                    end
                end
            end
            ST_WAIT: begin
                // the request holds until the memory answers
                // a memory that answers late just keeps the sequencer here
                next_memRdReq = !memRdValid;
                if (memRdValid) begin
                    next_acc = memRdData;
                    next_zeroFlag = (memRdData == `DATA_W'(0));
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state registers; reset is synchronous, so every edge samples nrst
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state <= ST_IDLE;
            acc <= `ACC_RESET;
            carryFlag <= 1'b0;
            zeroFlag <= 1'b0;
            fileWrEn <= 1'b0;
            fileWrAddr <= `FILE_ADDR_W'(0);
            fileWrData <= `DATA_W'(0);
            memRdReq <= 1'b0;
            memAddr <= `PTR_W'(0);
        end else begin
            state <= next_state;
            acc <= next_acc;
            carryFlag <= next_carryFlag;
            zeroFlag <= next_zeroFlag;
            fileWrEn <= next_fileWrEn;
            fileWrAddr <= next_fileWrAddr;
            fileWrData <= next_fileWrData;
            memRdReq <= next_memRdReq;
            memAddr <= next_memAddr;
        end
    end
endmodule // shift_move_indirect_exec

`default_nettype wire

//--- hw/shift_move_indirect_regs.svh
`ifndef SHIFT_MOVE_INDIRECT_REGS_SVH
`define SHIFT_MOVE_INDIRECT_REGS_SVH

// data path and address widths
`define DATA_W 8
`define FILE_ADDR_W 7
`define PTR_W 16
`define OFFSET_W 6

// update mode field codes
`define MODE_PRE_INC 2'h0
`define MODE_PRE_DEC 2'h1
`define MODE_POST_INC 2'h2
`define MODE_POST_DEC 2'h3

// field positions inside the update mode field
`define MODE_DOWN_BIT 0
`define MODE_POST_BIT 1

// destination selector values
`define DEST_ACC 1'h0
`define DEST_FILE 1'h1

// reset values
`define ACC_RESET 8'h00
`define PTR_RESET 16'h0000

`endif

//--- hw/shift_move_indirect_pkg.sv
`default_nettype none
package shift_move_indirect_pkg;

    // operation presented by the instruction decoder
    typedef enum logic [2:0] {
        OP_SHIFT_LEFT_LOGICAL = 3'h0,
        OP_SHIFT_RIGHT_LOGICAL = 3'h1,
        OP_MOVE_FILE = 3'h2,
        OP_INDIRECT_LOAD_ACC = 3'h3,
        OP_INDIRECT_LOAD_OFFSET = 3'h4
    } op_t;

    // sequencer states for the indirect load
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ISSUE = 2'h1,
        ST_WAIT = 2'h2
    } state_t;

endpackage

`default_nettype wire

//--- hw/pointer_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "shift_move_indirect_regs.svh"

module pointer_unit #(
    parameter int WIDTH = `PTR_W
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic loadEn,
    input wire logic [WIDTH-1:0] loadData,
    input wire logic stepEn,
    input wire logic stepDown,
    output logic [WIDTH-1:0] value
);
    logic [WIDTH-1:0] next_value;

    // a step wraps at both ends because the sum is cut back to WIDTH
    always_comb begin
        next_value = value;
        if (loadEn) begin
            next_value = loadData;
        end else if (stepEn) begin
            if (stepDown) begin
                next_value = value - WIDTH'(1);
            end else begin
                next_value = value + WIDTH'(1);
            end
        end
    end

    // pointer register with synchronous reset
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            value <= WIDTH'(`PTR_RESET);
        end else begin
            value <= next_value;
        end
    end
endmodule // pointer_unit

`default_nettype wire

//--- testbench/shift_move_indirect_exec_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "shift_move_indirect_regs.svh"
module shift_move_indirect_exec_sva
    import shift_move_indirect_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic opValid,
    input wire logic destSel,
    input wire logic ptrIndex,
    input wire logic ptrLoadEn,
    input wire op_t opCode,
    input wire logic [`FILE_ADDR_W-1:0] fileAddr,
    input wire logic [`FILE_ADDR_W-1:0] fileWrAddr,
    input wire logic [`DATA_W-1:0] fileData,
    input wire logic [`DATA_W-1:0] memRdData,
    input wire logic [`DATA_W-1:0] acc,
    input wire logic [`DATA_W-1:0] fileWrData,
    input wire logic [1:0] updateMode,
    input wire logic [`OFFSET_W-1:0] offset,
    input wire logic memRdValid,
    input wire logic opReady,
    input wire logic carryFlag,
    input wire logic zeroFlag,
    input wire logic fileWrEn,
    input wire logic memRdReq,
    input wire logic [`PTR_W-1:0] memAddr,
    input wire logic [`PTR_W-1:0] ptr0,
    input wire logic [`PTR_W-1:0] ptr1
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic take;
    logic [`PTR_W-1:0] sel;
    // accepted op and the pointer it names
    assign take = opValid && opReady;
    assign sel = ptrIndex ? ptr1 : ptr0;
    property p_shl;
        take && opCode == OP_SHIFT_LEFT_LOGICAL && destSel |=> fileWrEn &&
        fileWrData == {$past(fileData[6:0]), 1'b0} &&
        carryFlag == $past(fileData[7]);
    endproperty
    a_shl: assert property (p_shl) else $error("left shift wrong");
    property p_shr;
        take && opCode == OP_SHIFT_RIGHT_LOGICAL && !destSel |=>
        acc == {1'b0, $past(fileData[7:1])} && carryFlag == $past(fileData[0]);
    endproperty
    a_shr: assert property (p_shr) else $error("right shift wrong");
    property p_zsh;
        take && opCode == OP_SHIFT_LEFT_LOGICAL |=>
        zeroFlag == ($past(fileData[6:0]) == 7'h00);
    endproperty
    a_zsh: assert property (p_zsh) else $error("shift zero wrong");
    property p_mov;
        take && opCode == OP_MOVE_FILE && destSel |=> fileWrEn &&
        fileWrData == $past(fileData) && fileWrAddr == $past(fileAddr);
    endproperty
    a_mov: assert property (p_mov) else $error("move wrong");
    property p_movz;
        take && opCode == OP_MOVE_FILE |=> opReady &&
        zeroFlag == ($past(fileData) == 8'h00);
    endproperty
    a_movz: assert property (p_movz)
        else $error("move flag wrong");
    property p_pre;
        take && opCode == OP_INDIRECT_LOAD_ACC && !updateMode[1] && !ptrLoadEn
        |=> memRdReq && !opReady && memAddr == ($past(updateMode[0]) ?
        $past(sel) - 16'h0001 : $past(sel) + 16'h0001);
    endproperty
    a_pre: assert property (p_pre)
        else $error("pre step wrong");
    property p_off;
        take && opCode == OP_INDIRECT_LOAD_OFFSET && !ptrLoadEn |=>
        memAddr == $past(sel) + {{10{$past(offset[5])}}, $past(offset)};
    endproperty
    a_off: assert property (p_off) else $error("offset wrong");
    property p_ld;
        memRdReq && memRdValid |=> !memRdReq && acc == $past(memRdData) &&
        zeroFlag == ($past(memRdData) == 8'h00);
    endproperty
    a_ld: assert property (p_ld) else $error("load wrong");
endmodule // shift_move_indirect_exec_sva
bind shift_move_indirect_exec shift_move_indirect_exec_sva
    shift_move_indirect_exec_sva_inst (.*);
`default_nettype wire

//--- testbench/shift_move_indirect_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "shift_move_indirect_regs.svh"
module shift_move_indirect_exec_tb;
    import shift_move_indirect_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0, opValid = 1'b0, destSel = 1'b0;
    logic ptrIndex = 1'b0, ptrLoadEn = 1'b0, ptrLoadSel = 1'b0;
    logic memRdValid = 1'b0;
    op_t opCode = OP_MOVE_FILE;
    logic [6:0] fileAddr = 7'h7F;
    logic [7:0] fileData = 8'h00, memRdData = 8'h00;
    logic [1:0] updateMode = 2'h0;
    logic [5:0] offset = 6'h00;
    logic [15:0] ptrLoadData = 16'h0000;
    logic opReady, carryFlag, zeroFlag, fileWrEn, memRdReq;
    logic [7:0] acc, fileWrData;
    logic [6:0] fileWrAddr;
    logic [15:0] memAddr, ptr0, ptr1;
    logic [15:0] p [2];
    int miscompares = 0;
    int n_compared = 0;
    shift_move_indirect_exec shift_move_indirect_exec_inst (.*);
    // 250 MHz core clock
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] act, input logic [15:0] exp);
        n_compared++;
        if (act !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h want %h", $time, act, exp);
        end
    endtask
    task automatic summarize();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one op held for a single cycle; results read a cycle later
    task automatic issue(input op_t c, input logic [7:0] d, input logic s);
        @(negedge ref_clk);
        opValid = 1'b1;
        opCode = c;
        fileData = d;
        destSel = s;
        @(negedge ref_clk);
        opValid = 1'b0;
        fileData = ~d;
    endtask
    task automatic shifts();
        issue(OP_SHIFT_LEFT_LOGICAL, 8'h81, 1'b1);
        chk({fileWrEn, fileWrData, fileWrAddr}, 16'h817F);
        chk({carryFlag, zeroFlag}, 16'h0002);
        issue(OP_SHIFT_RIGHT_LOGICAL, 8'h01, 1'b0);
        chk({fileWrEn, acc, carryFlag, zeroFlag}, 16'h0003);
        issue(OP_SHIFT_LEFT_LOGICAL, 8'h40, 1'b0);
        chk({acc, carryFlag, zeroFlag}, 16'h0200);
    endtask
    task automatic moves();
        issue(OP_MOVE_FILE, 8'hA5, 1'b0);
        chk({acc, opReady, zeroFlag}, 16'h0296);
        fileAddr = 7'h2A;
        issue(OP_MOVE_FILE, 8'h00, 1'b1);
        chk({fileWrEn, fileWrData, fileWrAddr}, 16'h802A);
        chk({acc, zeroFlag}, 16'h014B);
    endtask
    task automatic load(input logic s, input logic [15:0] v);
        @(negedge ref_clk);
        ptrLoadEn = 1'b1;
        ptrLoadSel = s;
        ptrLoadData = v;
        p[s] = v;
        @(negedge ref_clk);
        ptrLoadEn = 1'b0;
    endtask
    // indirect load; address and pointer predicted from the bench copy
    task automatic indir(input op_t c, input logic i, input logic [1:0] m,
            input logic [5:0] k, input logic [7:0] d);
        logic [15:0] up;
        logic [15:0] ea;
        up = m[0] ? p[i] - 16'h0001 : p[i] + 16'h0001;
        ea = m[1] ? p[i] : up;
        if (c == OP_INDIRECT_LOAD_OFFSET)
            ea = p[i] + {{10{k[5]}}, k};
        else
            p[i] = up;
        @(negedge ref_clk);
        opValid = 1'b1;
        opCode = c;
        ptrIndex = i;
        updateMode = m;
        offset = k;
        @(negedge ref_clk);
        opValid = 1'b0;
        chk({memRdReq, opReady}, 16'h0002);
        chk(memAddr, ea);
        chk(i ? ptr1 : ptr0, p[i]);
        memRdValid = 1'b1;
        memRdData = d;
        @(negedge ref_clk);
        memRdValid = 1'b0;
        memRdData = ~d;
        chk({acc, zeroFlag, memRdReq}, {6'h00, d, d == 8'h00, 1'b0});
    endtask
    task automatic pointers();
        load(1'b0, 16'hFFFF);
        load(1'b1, 16'h0000);
        indir(OP_INDIRECT_LOAD_ACC, 1'b0, 2'h0, 6'h00, 8'h3C);
        indir(OP_INDIRECT_LOAD_ACC, 1'b1, 2'h1, 6'h00, 8'h00);
        indir(OP_INDIRECT_LOAD_ACC, 1'b1, 2'h2, 6'h00, 8'h5A);
        indir(OP_INDIRECT_LOAD_ACC, 1'b0, 2'h3, 6'h00, 8'h01);
        indir(OP_INDIRECT_LOAD_OFFSET, 1'b0, 2'h0, 6'h20, 8'h77);
        indir(OP_INDIRECT_LOAD_OFFSET, 1'b1, 2'h3, 6'h1F, 8'h00);
    endtask
    // guard against a hang
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
        chk({acc, carryFlag, zeroFlag, opReady, memRdReq}, 16'h0002);
        chk(ptr0 | ptr1 | memAddr, 16'h0000);
        shifts();
        moves();
        pointers();
        summarize();
    end
endmodule // shift_move_indirect_exec_tb
`default_nettype wire
